// File: verilog/gpf_port.sv
// Eight-bit port with per-pin direction, function routing and boot-select sampling.
`timescale 1ns/1ps
`default_nettype none
module gpf_port (
  input wire logic pclk, // System clock, 125 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // Bus select.
  input wire logic penable, // Bus access phase.
  input wire logic pwrite, // Bus direction, high for write.
  input wire logic [11:0] paddr, // Bus byte address inside the window.
  input wire logic [31:0] pwdata, // Bus write data.
  output logic [31:0] prdata, // Bus read data.
  output logic pready, // Bus transfer complete.
  output logic pslverr, // Bus error for unmapped offsets.
  input wire logic [7:0] pin_in, // Pin levels seen at the pads.
  output logic [7:0] pin_out, // Pin output levels.
  output logic [7:0] pin_oe, // Pin driver enables, high while driving.
  output logic [7:0] pin_pullup, // Pad pull-up enables.
  output logic [7:0] pin_input_buffer_en, // Pad input buffer enables.
  input wire logic deepest_stop_mode, // Deepest stop mode indication.
  input wire logic timer_output, // Timer output to route onto pin zero.
  output logic timer_capture_input_zero, // Pin four to timer capture zero.
  output logic timer_capture_input_one, // Pin five to timer capture one.
  output logic external_interrupt_six, // Pin four interrupt line.
  output logic external_interrupt_seven, // Pin five interrupt line.
  output logic single_chip_mode, // High: boot from flash; low: boot program.
  output logic boot_done, // High once the boot pin has been sampled.
  output logic irq // Level interrupt for unmasked events.
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Merges write data into a register, touching only implemented bits.
  function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] msk);
    wmerge = (old & ~msk) | (wd & msk);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0] sync_first; // First synchroniser stage, read only by the second.
  logic [7:0] pin_sync; // Synchronised pin levels.
  logic [7:0] pin_data; // Data register.
  logic [7:0] output_enable; // Output control register.
  logic [7:0] interrupt_route_select; // Interrupt function register.
  logic [7:0] timer_route_select; // Timer function register.
  logic [7:0] drive_type_select; // Open-drain register.
  logic [7:0] pullup_enable; // Pull-up register.
  logic [7:0] input_enable; // Input control register.
  logic [1:0] event_status; // Sticky interrupt-line rising edges.
  logic [1:0] event_mask; // Event enables.
  logic [1:0] boot_wait; // Cycles since reset release.
  gpf_pkg::gpf_bus_t bus_state; // Bus handshake state.
  logic [7:0] next_pin_data;
  logic [7:0] next_output_enable;
  logic [7:0] next_interrupt_route_select;
  logic [7:0] next_timer_route_select;
  logic [7:0] next_drive_type_select;
  logic [7:0] next_pullup_enable;
  logic [7:0] next_input_enable;
  logic [1:0] next_event_status;
  logic [1:0] next_event_mask;
  logic [1:0] next_boot_wait;
  logic next_single_chip_mode;
  logic next_boot_done;
  gpf_pkg::gpf_bus_t next_bus_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] next_pin_pullup;
  logic [7:0] next_pin_input_buffer_en;
  logic next_int_six;
  logic next_int_seven;
  logic next_cap_zero;
  logic next_cap_one;
  logic next_irq;
  logic [7:0] read_level; // Data as seen by a read.
  logic [7:0] drive_val; // Value each pin would drive.
  logic [7:0] general; // Pins in general-purpose mode.
  logic wr_fire; // A write completes at this edge.
  logic addr_ok; // The offset is mapped.

  // --------------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------------
  // Pads are asynchronous, so two stages come before any logic reads them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_first <= gpf_pkg::RST_ZERO;
      pin_sync <= gpf_pkg::RST_ZERO;
    end else begin
      sync_first <= pin_in;
      pin_sync <= sync_first;
    end
  end

  // --------------------------------------------------------------------------
  // Bus handshake and register file
  // --------------------------------------------------------------------------
  // One wait state: the answer is computed in the first access cycle and
  // pready rises in the second, so all bus outputs come from flip-flops.
  always_comb begin
    next_bus_state = bus_state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;
    next_pin_data = pin_data;
    next_output_enable = output_enable;
    next_interrupt_route_select = interrupt_route_select;
    next_timer_route_select = timer_route_select;
    next_drive_type_select = drive_type_select;
    next_pullup_enable = pullup_enable;
    next_input_enable = input_enable;
    next_event_mask = event_mask;
    wr_fire = psel && penable && pready && pwrite;
    // A read of the data register shows the pin level where input is on.
    read_level = pin_sync & input_enable;
    addr_ok = 1'b1;
    if (paddr == gpf_pkg::OFS_PIN_DATA) begin
      next_prdata = {24'h000000, read_level};
    end else if (paddr == gpf_pkg::OFS_OUTPUT_ENABLE) begin
      next_prdata = {24'h000000, output_enable};
    end else if (paddr == gpf_pkg::OFS_INTERRUPT_ROUTE_SELECT) begin
      next_prdata = {24'h000000, interrupt_route_select};
    end else if (paddr == gpf_pkg::OFS_TIMER_ROUTE_SELECT) begin
      next_prdata = {24'h000000, timer_route_select};
    end else if (paddr == gpf_pkg::OFS_DRIVE_TYPE_SELECT) begin
      next_prdata = {24'h000000, drive_type_select};
    end else if (paddr == gpf_pkg::OFS_PULLUP_ENABLE) begin
      next_prdata = {24'h000000, pullup_enable};
    end else if (paddr == gpf_pkg::OFS_INPUT_ENABLE) begin
      next_prdata = {24'h000000, input_enable};
    end else if (paddr == gpf_pkg::OFS_EVENT_STATUS) begin
      next_prdata = {30'h0, event_status};
    end else if (paddr == gpf_pkg::OFS_EVENT_MASK) begin
      next_prdata = {30'h0, event_mask};
    end else if (paddr == gpf_pkg::OFS_BOOT_STATUS) begin
      next_prdata = {30'h0, boot_done, single_chip_mode};
    end else begin
      // Reserved offsets answer zero with an error; nothing is stored.
      addr_ok = 1'b0;
    end
    case (bus_state)
      gpf_pkg::GPF_IDLE: begin
        if (psel && penable) begin
          next_bus_state = gpf_pkg::GPF_WAIT;
          next_pready = 1'b1;
          next_pslverr = !addr_ok;
        end
      end
      gpf_pkg::GPF_WAIT: begin
        // The transfer ends at this edge; read data drops back to zero.
        next_bus_state = gpf_pkg::GPF_DONE;
      end
      default: begin
        next_bus_state = gpf_pkg::GPF_IDLE;
      end
    endcase
    // Read data stands only in the cycle in which pready is high.
    if (!(bus_state == gpf_pkg::GPF_IDLE && psel && penable && !pwrite)) begin
      next_prdata = 32'h00000000;
    end
    if (wr_fire) begin
      if (paddr == gpf_pkg::OFS_PIN_DATA) begin
        next_pin_data = pwdata[7:0];
      end else if (paddr == gpf_pkg::OFS_OUTPUT_ENABLE) begin
        next_output_enable = pwdata[7:0];
      end else if (paddr == gpf_pkg::OFS_INTERRUPT_ROUTE_SELECT) begin
        next_interrupt_route_select = wmerge(interrupt_route_select, pwdata[7:0],
                                             gpf_pkg::MASK_INTERRUPT_ROUTE);
      end else if (paddr == gpf_pkg::OFS_TIMER_ROUTE_SELECT) begin
        next_timer_route_select = wmerge(timer_route_select, pwdata[7:0],
                                         gpf_pkg::MASK_TIMER_ROUTE);
      end else if (paddr == gpf_pkg::OFS_DRIVE_TYPE_SELECT) begin
        next_drive_type_select = pwdata[7:0];
      end else if (paddr == gpf_pkg::OFS_PULLUP_ENABLE) begin
        // Bit zero is forced on: the boot pin must never float.
        next_pullup_enable = pwdata[7:0] | gpf_pkg::MASK_PIN_ZERO;
      end else if (paddr == gpf_pkg::OFS_INPUT_ENABLE) begin
        next_input_enable = wmerge(input_enable, pwdata[7:0],
                                   gpf_pkg::MASK_INPUT_ENABLE);
      end else if (paddr == gpf_pkg::OFS_EVENT_MASK) begin
        next_event_mask = pwdata[1:0] & gpf_pkg::MASK_EVENTS;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= gpf_pkg::GPF_IDLE;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pin_data <= gpf_pkg::RST_ZERO;
      output_enable <= gpf_pkg::RST_ZERO;
      interrupt_route_select <= gpf_pkg::RST_ZERO;
      timer_route_select <= gpf_pkg::RST_ZERO;
      drive_type_select <= gpf_pkg::RST_ZERO;
      pullup_enable <= gpf_pkg::RST_PULLUP_ENABLE;
      input_enable <= gpf_pkg::RST_ZERO;
      event_mask <= 2'h0;
    end else begin
      bus_state <= next_bus_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      pin_data <= next_pin_data;
      output_enable <= next_output_enable;
      interrupt_route_select <= next_interrupt_route_select;
      timer_route_select <= next_timer_route_select;
      drive_type_select <= next_drive_type_select;
      pullup_enable <= next_pullup_enable;
      input_enable <= next_input_enable;
      event_mask <= next_event_mask;
    end
  end

  // --------------------------------------------------------------------------
  // Boot-select capture
  // --------------------------------------------------------------------------
  // The synchroniser is cleared by reset, so the capture waits until it has
  // refilled with the real pad level before the mode is latched.
  always_comb begin
    next_boot_wait = boot_wait;
    next_boot_done = boot_done;
    next_single_chip_mode = single_chip_mode;
    if (!boot_done) begin
      if (boot_wait == gpf_pkg::BOOT_SAMPLE_WAIT) begin
        next_boot_done = 1'b1;
        next_single_chip_mode = pin_sync[gpf_pkg::BIT_PIN_ZERO];
      end else begin
        next_boot_wait = boot_wait + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_wait <= 2'h0;
      boot_done <= 1'b0;
      single_chip_mode <= 1'b0;
    end else begin
      boot_wait <= next_boot_wait;
      boot_done <= next_boot_done;
      single_chip_mode <= next_single_chip_mode;
    end
  end

  // --------------------------------------------------------------------------
  // Pad control, routing and events
  // --------------------------------------------------------------------------
  always_comb begin
    general = ~(interrupt_route_select | timer_route_select);
    drive_val = pin_data;
    next_pin_oe = output_enable & general;
    if (timer_route_select[gpf_pkg::BIT_PIN_ZERO]) begin
      // Timer function on pin zero drives the timer's output.
      drive_val[gpf_pkg::BIT_PIN_ZERO] = timer_output;
      next_pin_oe[gpf_pkg::BIT_PIN_ZERO] = output_enable[gpf_pkg::BIT_PIN_ZERO];
    end
    // Open-drain pins only pull low; a one releases the pad.
    next_pin_oe = next_pin_oe & ~(drive_type_select & drive_val);
    next_pin_out = drive_val;
    next_pin_pullup = pullup_enable;
    next_pin_input_buffer_en = input_enable;
    // Hold the boot pin's buffer and pull-up until its level is latched.
    if (!boot_done) begin
      next_pin_input_buffer_en = next_pin_input_buffer_en | gpf_pkg::RST_INPUT_BUFFER;
      next_pin_pullup = next_pin_pullup | gpf_pkg::MASK_PIN_ZERO;
    end
    // Interrupt lines ignore the function bits, a known hazard for software.
    next_int_six = input_enable[gpf_pkg::BIT_PIN_FOUR]
                   && pin_sync[gpf_pkg::BIT_PIN_FOUR] && !deepest_stop_mode;
    next_int_seven = input_enable[gpf_pkg::BIT_PIN_FIVE]
                     && pin_sync[gpf_pkg::BIT_PIN_FIVE] && !deepest_stop_mode;
    next_cap_zero = timer_route_select[gpf_pkg::BIT_PIN_FOUR]
                    && pin_sync[gpf_pkg::BIT_PIN_FOUR];
    next_cap_one = timer_route_select[gpf_pkg::BIT_PIN_FIVE]
                   && pin_sync[gpf_pkg::BIT_PIN_FIVE];
    // Rising edges set sticky bits; a set in the clearing cycle wins.
    next_event_status = event_status;
    if (wr_fire && paddr == gpf_pkg::OFS_EVENT_STATUS) begin
      next_event_status = event_status & ~pwdata[1:0];
    end
    if (next_int_six && !external_interrupt_six) begin
      next_event_status[gpf_pkg::EVT_INT_SIX] = 1'b1;
    end
    if (next_int_seven && !external_interrupt_seven) begin
      next_event_status[gpf_pkg::EVT_INT_SEVEN] = 1'b1;
    end
    next_irq = |(event_status & event_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= gpf_pkg::RST_ZERO;
      pin_oe <= gpf_pkg::RST_ZERO;
      pin_pullup <= gpf_pkg::RST_PULLUP_ENABLE;
      pin_input_buffer_en <= gpf_pkg::RST_INPUT_BUFFER;
      external_interrupt_six <= 1'b0;
      external_interrupt_seven <= 1'b0;
      timer_capture_input_zero <= 1'b0;
      timer_capture_input_one <= 1'b0;
      event_status <= 2'h0;
      irq <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pullup <= next_pin_pullup;
      pin_input_buffer_en <= next_pin_input_buffer_en;
      external_interrupt_six <= next_int_six;
      external_interrupt_seven <= next_int_seven;
      timer_capture_input_zero <= next_cap_zero;
      timer_capture_input_one <= next_cap_one;
      event_status <= next_event_status;
      irq <= next_irq;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions and covers
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ONE_WAIT: assert property (psel && penable && !pready && bus_state == gpf_pkg::GPF_IDLE
    |=> pready) else $error("pready did not follow one wait state");
  AST_READ_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_PULLUP_ZERO_KEPT: assert property (pin_pullup[0] && pullup_enable[0])
    else $error("boot pin pull-up dropped");
  AST_BOOT_BUFFER_OFF: assert property (boot_done |=> !pin_input_buffer_en[0])
    else $error("pin zero input buffer still on");
  AST_BOOT_CAPTURE: assert property ($rose(boot_done) |-> single_chip_mode == $past(pin_sync[0]))
    else $error("boot mode not taken from pin zero");
  AST_BOOT_HOLD: assert property (!boot_done |-> pin_pullup[0] && pin_input_buffer_en[0])
    else $error("boot pin not sampled with pull-up");
  AST_GP_DRIVE: assert property (general[3] && output_enable[3] && !drive_type_select[3]
    |=> pin_oe[3] && pin_out[3] == $past(pin_data[3])) else $error("pin three not driven");
  AST_ALT_NO_DRIVE: assert property (interrupt_route_select[4] |=> !pin_oe[4])
    else $error("routed pin still driven");
  AST_STOP_INT: assert property (deepest_stop_mode |=> !external_interrupt_six
    && !external_interrupt_seven) else $error("interrupt active in deepest stop");
  AST_IRQ_LEVEL: assert property (irq == $past(|(event_status & event_mask)))
    else $error("irq does not follow events");
  AST_OPEN_DRAIN: assert property (drive_type_select[2] && pin_data[2] && general[2]
    |=> !pin_oe[2]) else $error("open-drain pin drives high");

  COV_WRITE: cover property (wr_fire && paddr == gpf_pkg::OFS_OUTPUT_ENABLE);
  COV_READ_DATA: cover property (pready && !pwrite && paddr == gpf_pkg::OFS_PIN_DATA);
  COV_IRQ: cover property ($rose(irq));
  COV_SINGLE_CHIP: cover property ($rose(boot_done) && single_chip_mode);
  COV_BOOT_PROGRAM: cover property ($rose(boot_done) && !single_chip_mode);
endmodule
`default_nettype wire

// File: verilog/gpf_pkg.sv
// Constants shared by the eight-bit port with boot-select pin.
package gpf_pkg;
  // --------------------------------------------------------------------------
  // Register offsets (byte addresses inside the port window)
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_PIN_DATA = 12'h000;
  localparam logic [11:0] OFS_OUTPUT_ENABLE = 12'h004;
  localparam logic [11:0] OFS_INTERRUPT_ROUTE_SELECT = 12'h00C;
  localparam logic [11:0] OFS_TIMER_ROUTE_SELECT = 12'h010;
  localparam logic [11:0] OFS_DRIVE_TYPE_SELECT = 12'h028;
  localparam logic [11:0] OFS_PULLUP_ENABLE = 12'h02C;
  localparam logic [11:0] OFS_INPUT_ENABLE = 12'h038;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h040;
  localparam logic [11:0] OFS_EVENT_MASK = 12'h044;
  localparam logic [11:0] OFS_BOOT_STATUS = 12'h048;

  // --------------------------------------------------------------------------
  // Writable bit masks per register
  // --------------------------------------------------------------------------
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_INTERRUPT_ROUTE = 8'h30;
  localparam logic [7:0] MASK_TIMER_ROUTE = 8'h31;
  localparam logic [7:0] MASK_INPUT_ENABLE = 8'hFE;
  localparam logic [7:0] MASK_PIN_ZERO = 8'h01;
  localparam logic [1:0] MASK_EVENTS = 2'h3;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int BIT_PIN_ZERO = 0;
  localparam int BIT_PIN_FOUR = 4;
  localparam int BIT_PIN_FIVE = 5;
  localparam int EVT_INT_SIX = 0;
  localparam int EVT_INT_SEVEN = 1;
  localparam int BOOT_BIT_MODE = 0;
  localparam int BOOT_BIT_DONE = 1;

  // --------------------------------------------------------------------------
  // Reset values and timing counts
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PULLUP_ENABLE = 8'h01;
  localparam logic [7:0] RST_INPUT_BUFFER = 8'h01;
  localparam logic [1:0] BOOT_SAMPLE_WAIT = 2'h2;

  // Bus handshake states.
  typedef enum logic [1:0] {GPF_IDLE, GPF_WAIT, GPF_DONE} gpf_bus_t;
endpackage

// File: dv/gpf_pad_model.sv
// Board pad model that resolves each port pin from all of its drivers.
`timescale 1ns/1ps
`default_nettype none
module gpf_pad_model (
  input wire logic [7:0] pin_out, // Port drive levels.
  input wire logic [7:0] pin_oe, // Port drive enables.
  input wire logic [7:0] pin_pullup, // Port pull-up enables.
  input wire logic [7:0] ext_val, // Board source levels.
  input wire logic [7:0] ext_en, // Board source enables.
  output logic [7:0] pin_lvl // Resolved pad levels.
);
  // ---------------------------------------------
  // Resolution
  // ---------------------------------------------
  // A floating pad shows the inverse of the latch, so a stale value never passes.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pin_pullup[i]) begin
        pin_lvl[i] = 1'b1;
      end else begin
        pin_lvl[i] = ~pin_out[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/gpf_port_test.sv
// Self-checking bench for the eight-bit port over APB.
`timescale 1ns/1ps
`default_nettype none
module gpf_port_test;
  logic pclk, presetn, psel, penable, pwrite, stop, tmr_out, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, cap0, cap1, ei6, ei7, scm, bdone, irq;
  logic [7:0] pin_lvl, pin_out, pin_oe, pin_pu, pin_ibe, ext_val, ext_en;
  int n_errors = 0;
  int num_checks = 0;
  // Offsets, reset values and read-back after all ones, per register.
  logic [11:0] ofs [7] = '{12'h000, 12'h004, 12'h00C, 12'h010, 12'h028, 12'h02C, 12'h038};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] wm [7] = '{8'h00, 8'hFF, 8'h30, 8'h31, 8'hFF, 8'hFF, 8'hFE};
  gpf_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .pin_input_buffer_en(pin_ibe), .deepest_stop_mode(stop),
    .timer_output(tmr_out), .timer_capture_input_zero(cap0), .timer_capture_input_one(cap1),
    .external_interrupt_six(ei6), .external_interrupt_seven(ei7), .single_chip_mode(scm),
    .boot_done(bdone), .irq(irq));
  gpf_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that is never answered.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk({err, q}, {25'h0, e});
  endtask
  // Reset with the boot pin pulled high, or held low by the board.
  task automatic boot(input logic b);
    presetn <= 1'b0;
    ext_en <= {7'h0, ~b};
    ext_val <= 8'h00;
    repeat (3) @(posedge pclk);
    chk({pin_pu[0], pin_ibe[0], pin_oe[0]}, 3'b110);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({bdone, scm}, {1'b1, b});
    $display("boot test done");
  endtask
  // ---------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #40000;
    n_errors++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, stop, tmr_out} <= 5'h00;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    boot(1'b1);
    chk({pin_oe, pin_pu, pin_ibe}, 24'h000100);
    rd(12'h048, 8'h03);
    // Each register is set and cleared alone, so no pin gets two functions.
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], rv[i]);
      wr(ofs[i], 8'hFF);
      rd(ofs[i], wm[i]);
      wr(ofs[i], 8'h00);
    end
    // Reserved offsets are never touched; an unmapped one past them is probed.
    apb(1'b1, 12'h0FC, 32'hFF);
    chk({err, q}, 33'h1_0000_0000);
    $display("register test done");
    wr(12'h004, 8'hFF);
    wr(12'h000, 8'hA5);
    repeat (2) @(posedge pclk);
    chk({pin_oe, pin_out}, 16'hFFA5);
    wr(12'h028, 8'hFF);
    repeat (2) @(posedge pclk);
    chk(pin_oe, 8'h5A);
    wr(12'h028, 8'h00);
    wr(12'h004, 8'h0F);
    repeat (2) @(posedge pclk);
    chk(pin_oe, 8'h0F);
    $display("drive test done");
    wr(12'h004, 8'h00);
    wr(12'h040, 8'h03);
    ext_en <= 8'hFF;
    ext_val <= 8'h4B;
    wr(12'h038, 8'hFF);
    wr(12'h044, 8'h01);
    rd(12'h000, 8'h4A);
    ext_val <= 8'h5B;
    repeat (6) @(posedge pclk);
    chk({ei7, ei6, irq}, 3'b011);
    wr(12'h040, 8'h01);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    wr(12'h044, 8'h00);
    ext_val <= 8'h4B;
    repeat (4) @(posedge pclk);
    ext_val <= 8'h5B;
    repeat (6) @(posedge pclk);
    chk(irq, 1'b0);
    rd(12'h040, 8'h01);
    stop <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(ei6, 1'b0);
    stop <= 1'b0;
    $display("interrupt test done");
    wr(12'h010, 8'h11);
    wr(12'h004, 8'h01);
    tmr_out <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({cap1, cap0, pin_oe[0], pin_out[0]}, 4'b0111);
    $display("timer test done");
    boot(1'b0);
    rd(12'h048, 8'h02);
    finish_test();
  end
endmodule
`default_nettype wire
